// ---- cpt_pkg.sv ----
// Purpose: Constants for the content-protection transmitter register bank.
// Assumes: 25 MHz device clock, 8-bit register port, 8-bit register addresses.
// Notes: Interrupt, indirect status and mask registers sit in the spare 0xC8 block.
// Functional notes
// - Flag cascade limit error when downstream reports more than seven repeater levels.
// - Show downstream attached level count in a read-only 3-bit field.
// - Each key-list port read of a non-empty list returns next byte and advances read pointer; an empty list reads 0x00.
// - Serial master treats bus free after one idle second unless timeout disabled.
// - Integrity checked every 128th frame; frame 127 check unless disabled.
// - With checksum enable, send ones-complement checksum per colour after each line.
// - Test mode: enhanced check every 2, integrity every 16 frames; else 16/128.
// - Timer speedup bit shortens authentication timers.
// - Fast-mode bit selects master timing and is mirrored in indirect status.
// - Enhanced verification enable gates the every-16th-frame enhanced check.
// - Signalling-select bit picks enhanced or original encryption status signalling.
// - Repeater mode enable adds repeater authentication steps.
// - Two-bit mode: authenticated, register control, always, in-band per frame.
// - Receiver-detect event on detection; with qualify set, also needs receiver lock.
// - Mute bit ignores encryption status controls; settable only with enhanced signalling.
// - Configuration register resets to 0xA8.
// - Read-only key-list-ready flag shows downstream list and value complete.
// - In always-encrypt mode the encryption enable reads back as 1.
package cpt_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] ADDR_TOPOLOGY = 8'hA2;
	localparam logic [7:0] ADDR_KEY_LIST = 8'hA3;
	localparam logic [7:0] ADDR_DEBUG = 8'hC0;
	localparam logic [7:0] ADDR_CONFIG = 8'hC2;
	localparam logic [7:0] ADDR_INT_STATUS = 8'hC8;
	localparam logic [7:0] ADDR_INT_MASK = 8'hC9;
	localparam logic [7:0] ADDR_IND_STATUS = 8'hCA;
	localparam logic [7:0] CONFIG_RESET = 8'hA8;
	localparam logic [7:0] DEBUG_RESET = 8'h00;
	localparam logic [7:0] DEBUG_WMASK = 8'h5F;
	localparam logic [7:0] INT_WMASK = 8'h0F;
	// Debug register fields
	localparam int DBG_FAST = 0;
	localparam int DBG_SPEEDUP = 1;
	localparam int DBG_FC_TEST = 2;
	localparam int DBG_CSUM_EN = 3;
	localparam int DBG_SYNC_DIS = 4;
	localparam int DBG_TO_DIS = 6;
	// Configuration register fields
	localparam int CFG_MUTE = 0;
	localparam int CFG_DET_QUAL = 1;
	localparam int CFG_HOLD = 2;
	localparam int CFG_MODE_LO = 3;
	localparam int CFG_REPEATER = 5;
	localparam int CFG_EESS = 6;
	localparam int CFG_ENHANCED_VERIFICATION_ENABLE = 7;
	// Topology register fields
	localparam int TOPO_ERR = 3;
	localparam logic [3:0] MAX_CASCADE = 4'h7;
	// Interrupt and indirect status bits
	localparam int INT_RX_DETECT = 0;
	localparam int INT_CASCADE = 1;
	localparam int INT_KEY_READY = 2;
	localparam int INT_BUS_FREE = 3;
	localparam int IND_FAST = 0;
	localparam int IND_KEY_READY = 1;
	typedef enum logic [1:0] {
		CPT_ENC_AUTH = 2'b00,
		CPT_ENC_REG = 2'b01,
		CPT_ENC_ALWAYS = 2'b10,
		CPT_ENC_INBAND = 2'b11
	} cpt_enc_mode_t;
	// Key list storage
	localparam int KEY_DEPTH = 64;
	localparam int KEY_PTR_W = 6;
	// Frame periods, normal and test mode
	localparam logic [6:0] INTEG_MASK_NORMAL = 7'h7F;
	localparam logic [6:0] INTEG_MASK_TEST = 7'h0F;
	localparam logic [6:0] ENH_MASK_NORMAL = 7'h0F;
	localparam logic [6:0] ENH_MASK_TEST = 7'h01;
	// Timing
	localparam longint CLOCK_HZ = 25000000;
	localparam longint BUS_TIMEOUT_MS = 1000;
	localparam longint BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_MS * CLOCK_HZ / 1000;
	localparam longint AUTH_TICK_US = 1000;
	localparam longint AUTH_TICK_CYCLES = AUTH_TICK_US * CLOCK_HZ / 1000000;
	localparam int SPEEDUP_SHIFT = 4;
endpackage

// ---- cpt_regs.sv ----
// Purpose: Register bank and control logic of the content-protection transmitter.
// Assumes: One clock and synchronous active-high reset; protection engine on same clock.
// Notes: Link clock and data pins of the serial channel are sampled through two flops.
`timescale 1ns/1ns
module cpt_regs #(
	parameter logic [24:0] BUS_TIMEOUT = 25'(cpt_pkg::BUS_TIMEOUT_CYCLES),
	parameter logic [15:0] AUTH_TICK = 16'(cpt_pkg::AUTH_TICK_CYCLES)
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [cpt_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [cpt_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [cpt_pkg::DATA_W-1:0] reg_rdata,
	input wire logic topo_update,
	input wire logic [3:0] topo_levels,
	input wire logic key_list_clear,
	input wire logic key_byte_valid,
	input wire logic [7:0] key_byte,
	input wire logic key_list_done,
	input wire logic link_scl_in,
	input wire logic link_sda_in,
	output logic bus_free,
	output logic bus_fast_mode,
	input wire logic frame_start,
	input wire logic frame_inband_encrypt,
	input wire logic authenticated,
	input wire logic encryption_enable_control,
	output logic encryption_enable_readback,
	output logic frame_encrypt,
	output logic integrity_check,
	output logic integrity_sync_check,
	output logic enhanced_check,
	input wire logic pix_valid,
	input wire logic [7:0] pix_red,
	input wire logic [7:0] pix_green,
	input wire logic [7:0] pix_blue,
	input wire logic line_end,
	output logic csum_valid,
	output logic [7:0] csum_red,
	output logic [7:0] csum_green,
	output logic [7:0] csum_blue,
	output logic auth_timer_tick,
	output logic enhanced_signalling,
	output logic repeater_mode,
	output logic av_mute,
	input wire logic rx_detected,
	input wire logic rx_lock,
	output logic irq
);
	import cpt_pkg::*;

	logic [7:0] debug_reg, config_reg, topology_reg;
	logic [3:0] int_status, int_mask;
	logic key_list_ready;
	logic [7:0] key_mem [KEY_DEPTH];
	logic [KEY_PTR_W:0] key_wr_ptr, key_rd_ptr;
	logic wr_debug, wr_config, rd_key;
	logic [7:0] next_rdata, next_config;
	cpt_enc_mode_t enc_mode;
	logic [3:0] events;

	assign wr_debug = reg_wr && (reg_addr == ADDR_DEBUG);
	assign wr_config = reg_wr && (reg_addr == ADDR_CONFIG);
	assign rd_key = reg_rd && (reg_addr == ADDR_KEY_LIST);
	assign enc_mode = cpt_enc_mode_t'(config_reg[CFG_MODE_LO +: 2]);

	// Debug register
	always_ff @(posedge clock) begin
		if (rst) begin
			debug_reg <= DEBUG_RESET;
		end else if (wr_debug) begin
			debug_reg <= reg_wdata & DEBUG_WMASK;
		end
	end

	// Mute may only be raised while enhanced signalling is selected by the same write
	always_comb begin
		next_config = reg_wdata;
		if (!reg_wdata[CFG_EESS]) begin
			next_config[CFG_MUTE] = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			config_reg <= CONFIG_RESET;
		end else if (wr_config) begin
			config_reg <= next_config;
		end
	end

	// Topology report from the downstream repeater
	always_ff @(posedge clock) begin
		if (rst) begin
			topology_reg <= 8'h00;
		end else if (topo_update) begin
			topology_reg <= 8'h00;
			topology_reg[TOPO_ERR] <= topo_levels > MAX_CASCADE;
			topology_reg[2:0] <= topo_levels[2:0];
		end
	end

	// Key list store; bytes beyond the depth are dropped
	always_ff @(posedge clock) begin
		if (key_byte_valid && !key_wr_ptr[KEY_PTR_W]) begin
			key_mem[key_wr_ptr[KEY_PTR_W-1:0]] <= key_byte;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || key_list_clear) begin
			key_wr_ptr <= '0;
		end else if (key_byte_valid && !key_wr_ptr[KEY_PTR_W]) begin
			key_wr_ptr <= key_wr_ptr + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || key_list_clear) begin
			key_rd_ptr <= '0;
		end else if (rd_key && key_rd_ptr != key_wr_ptr) begin
			key_rd_ptr <= key_rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || key_list_clear) begin
			key_list_ready <= 1'b0;
		end else if (key_list_done) begin
			key_list_ready <= 1'b1;
		end
	end

	// Read path; data stands for the one cycle after the strobe only
	always_comb begin
		next_rdata = 8'h00;
		case (reg_addr)
			ADDR_TOPOLOGY: next_rdata = topology_reg;
			ADDR_KEY_LIST: begin
				next_rdata = (key_rd_ptr != key_wr_ptr) ? key_mem[key_rd_ptr[KEY_PTR_W-1:0]] : 8'h00;
			end
			ADDR_DEBUG: next_rdata = debug_reg;
			ADDR_CONFIG: next_rdata = config_reg;
			ADDR_INT_STATUS: next_rdata = {4'h0, int_status};
			ADDR_INT_MASK: next_rdata = {4'h0, int_mask};
			ADDR_IND_STATUS: begin
				next_rdata[IND_FAST] = debug_reg[DBG_FAST];
				next_rdata[IND_KEY_READY] = key_list_ready;
			end
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Serial channel pins: two flops, then a third stage for change detection
	logic [1:0] scl_sync, sda_sync;
	logic scl_prev, sda_prev, bus_activity, bus_free_rise;
	logic [24:0] idle_count;

	always_ff @(posedge clock) begin
		if (rst) begin
			scl_sync <= 2'b11;
			sda_sync <= 2'b11;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], link_scl_in};
			sda_sync <= {sda_sync[0], link_sda_in};
			scl_prev <= scl_sync[1];
			sda_prev <= sda_sync[1];
		end
	end

	assign bus_activity = (scl_prev != scl_sync[1]) || (sda_prev != sda_sync[1]);
	// Same condition that sets bus_free, so one event per quiet spell
	assign bus_free_rise = !bus_free && !debug_reg[DBG_TO_DIS] && !bus_activity && idle_count > BUS_TIMEOUT;

	// Counter saturates so a long quiet bus never wraps back to busy
	always_ff @(posedge clock) begin
		if (rst || bus_activity) begin
			idle_count <= '0;
		end else if (idle_count <= BUS_TIMEOUT) begin
			idle_count <= idle_count + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || bus_activity || debug_reg[DBG_TO_DIS]) begin
			bus_free <= 1'b0;
		end else if (idle_count > BUS_TIMEOUT) begin
			bus_free <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			bus_fast_mode <= 1'b0;
		end else begin
			bus_fast_mode <= debug_reg[DBG_FAST];
		end
	end

	// Frame counter for link verification
	logic [6:0] frame_count, next_frame, integ_mask, enh_mask;

	assign next_frame = frame_count + 1'b1;
	assign integ_mask = debug_reg[DBG_FC_TEST] ? INTEG_MASK_TEST : INTEG_MASK_NORMAL;
	assign enh_mask = debug_reg[DBG_FC_TEST] ? ENH_MASK_TEST : ENH_MASK_NORMAL;

	always_ff @(posedge clock) begin
		if (rst) begin
			frame_count <= '0;
		end else if (frame_start) begin
			frame_count <= next_frame;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			integrity_check <= 1'b0;
			integrity_sync_check <= 1'b0;
			enhanced_check <= 1'b0;
		end else begin
			integrity_check <= frame_start && ((next_frame & integ_mask) == 7'h00);
			integrity_sync_check <= frame_start && !debug_reg[DBG_SYNC_DIS]
				&& ((next_frame & integ_mask) == integ_mask);
			enhanced_check <= frame_start && config_reg[CFG_ENHANCED_VERIFICATION_ENABLE]
				&& ((next_frame & enh_mask) == 7'h00);
		end
	end

	// Encryption decision, taken once per frame
	logic next_encrypt;

	always_comb begin
		case (enc_mode)
			CPT_ENC_AUTH: next_encrypt = authenticated;
			CPT_ENC_REG: next_encrypt = authenticated && encryption_enable_control;
			CPT_ENC_ALWAYS: next_encrypt = 1'b1;
			CPT_ENC_INBAND: next_encrypt = frame_inband_encrypt;
			default: next_encrypt = 1'b0;
		endcase
	end

	// While muted the last decision is held, status controls ignored
	always_ff @(posedge clock) begin
		if (rst) begin
			frame_encrypt <= 1'b0;
		end else if (frame_start && !config_reg[CFG_MUTE]) begin
			frame_encrypt <= next_encrypt;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			encryption_enable_readback <= 1'b0;
		end else begin
			encryption_enable_readback <= (enc_mode == CPT_ENC_ALWAYS) || encryption_enable_control;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			enhanced_signalling <= 1'b0;
			repeater_mode <= 1'b0;
			av_mute <= 1'b0;
		end else begin
			enhanced_signalling <= config_reg[CFG_EESS];
			repeater_mode <= config_reg[CFG_REPEATER];
			av_mute <= config_reg[CFG_MUTE];
		end
	end

	// Per-line ones-complement checksums, end-around carry
	logic [7:0] acc [3];
	logic [7:0] pix [3];

	assign pix[0] = pix_red;
	assign pix[1] = pix_green;
	assign pix[2] = pix_blue;

	for (genvar c = 0; c < 3; c++) begin : g_csum
		logic [8:0] sum;
		assign sum = {1'b0, acc[c]} + {1'b0, pix[c]};
		always_ff @(posedge clock) begin
			if (rst || line_end) begin
				acc[c] <= 8'h00;
			end else if (pix_valid) begin
				acc[c] <= sum[7:0] + {7'h00, sum[8]};
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			csum_valid <= 1'b0;
			csum_red <= 8'h00;
			csum_green <= 8'h00;
			csum_blue <= 8'h00;
		end else begin
			csum_valid <= line_end && debug_reg[DBG_CSUM_EN];
			if (line_end && debug_reg[DBG_CSUM_EN]) begin
				csum_red <= ~acc[0];
				csum_green <= ~acc[1];
				csum_blue <= ~acc[2];
			end
		end
	end

	// Authentication timer base; speedup trades accuracy for test time
	logic [15:0] tick_count;
	logic [15:0] tick_limit;

	assign tick_limit = debug_reg[DBG_SPEEDUP] ? (AUTH_TICK >> SPEEDUP_SHIFT) : AUTH_TICK;

	always_ff @(posedge clock) begin
		if (rst) begin
			tick_count <= '0;
			auth_timer_tick <= 1'b0;
		end else if (tick_count + 1'b1 >= tick_limit) begin
			tick_count <= '0;
			auth_timer_tick <= 1'b1;
		end else begin
			tick_count <= tick_count + 1'b1;
			auth_timer_tick <= 1'b0;
		end
	end

	// Receiver detect, optionally qualified by lock
	logic rx_seen;
	logic rx_detect_event;

	assign rx_detect_event = !rx_seen && rx_detected && (!config_reg[CFG_DET_QUAL] || rx_lock);

	always_ff @(posedge clock) begin
		if (rst || !rx_detected) begin
			rx_seen <= 1'b0;
		end else if (rx_detect_event) begin
			rx_seen <= 1'b1;
		end
	end

	// Interrupts: set wins over write-one-to-clear
	logic topo_err_prev;
	logic key_ready_prev;

	always_ff @(posedge clock) begin
		if (rst) begin
			topo_err_prev <= 1'b0;
			key_ready_prev <= 1'b0;
		end else begin
			topo_err_prev <= topology_reg[TOPO_ERR];
			key_ready_prev <= key_list_ready;
		end
	end

	assign events[INT_RX_DETECT] = rx_detect_event;
	assign events[INT_CASCADE] = topology_reg[TOPO_ERR] && !topo_err_prev;
	assign events[INT_KEY_READY] = key_list_ready && !key_ready_prev;
	assign events[INT_BUS_FREE] = bus_free_rise;

	always_ff @(posedge clock) begin
		if (rst) begin
			int_status <= 4'h0;
		end else if (reg_wr && reg_addr == ADDR_INT_STATUS) begin
			int_status <= (int_status & ~reg_wdata[3:0]) | events;
		end else begin
			int_status <= int_status | events;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			int_mask <= 4'h0;
		end else if (reg_wr && reg_addr == ADDR_INT_MASK) begin
			int_mask <= reg_wdata[3:0] & INT_WMASK[3:0];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status & int_mask);
		end
	end

endmodule

// ---- cpt_regs_sva.sv ----
// Purpose: Port-level checks for the protection register bank.
// Assumes: One clock, rst synchronous active high.
// Notes: Sees only top ports, so config state is inferred from writes.
`timescale 1ns/1ns
module cpt_chk (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic frame_start,
	input wire logic integrity_check,
	input wire logic enhanced_check,
	input wire logic line_end,
	input wire logic csum_valid,
	input wire logic bus_fast_mode,
	input wire logic enhanced_signalling,
	input wire logic av_mute,
	input wire logic encryption_enable_readback
);
	logic cfg_w;
	logic dbg_w;
	assign cfg_w = reg_wr && reg_addr == 8'hC2;
	assign dbg_w = reg_wr && reg_addr == 8'hC0;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence cfg_then_read;
		cfg_w ##1 (reg_rd && reg_addr == 8'hC2);
	endsequence
	sequence always_mode_set;
		cfg_w && reg_wdata[4:3] == 2'b10 ##1 !cfg_w;
	endsequence
	chk_integ_frame: assert property (integrity_check |-> $past(frame_start))
		else $error("integrity pulse without frame start");
	chk_enh_frame: assert property (enhanced_check |-> $past(frame_start))
		else $error("enhanced pulse without frame start");
	chk_csum_line: assert property (csum_valid |-> $past(line_end))
		else $error("checksum without line end");
	chk_mute_eess: assert property (av_mute |-> enhanced_signalling)
		else $error("mute without enhanced signalling");
	chk_always_one: assert property (always_mode_set |=> encryption_enable_readback)
		else $error("enable readback not one in always mode");
	chk_fast_mirror: assert property (dbg_w ##1 !dbg_w |=> bus_fast_mode == $past(reg_wdata[0], 2))
		else $error("fast mode does not follow debug bit");
	chk_topo_rsvd: assert property (reg_rd && reg_addr == 8'hA2 |=> reg_rdata[7:4] == 4'h0)
		else $error("topology reserved bits not zero");
	chk_cfg_back: assert property (cfg_then_read |=> reg_rdata[5:1] == $past(reg_wdata[5:1], 2))
		else $error("config readback differs from write");
endmodule
bind cpt_regs cpt_chk u_chk (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_start(frame_start),
	.integrity_check(integrity_check), .enhanced_check(enhanced_check), .line_end(line_end),
	.csum_valid(csum_valid), .bus_fast_mode(bus_fast_mode), .enhanced_signalling(enhanced_signalling),
	.av_mute(av_mute), .encryption_enable_readback(encryption_enable_readback));

// ---- cpt_rx_model.sv ----
// Purpose: Downstream receiver model feeding topology, key list and link.
// Assumes: Tasks are called just after a rising edge.
// Notes: Serial lines have pull-ups, so idle is high.
`timescale 1ns/1ns
module cpt_rx_model (
	input wire logic clock,
	output logic topo_update,
	output logic [3:0] topo_levels,
	output logic key_list_clear,
	output logic key_byte_valid,
	output logic [7:0] key_byte,
	output logic key_list_done,
	output logic link_scl_in,
	output logic link_sda_in,
	output logic rx_detected,
	output logic rx_lock
);
	initial begin
		{topo_update, topo_levels, key_list_clear, key_byte_valid, key_byte, key_list_done} = '0;
		{link_scl_in, link_sda_in, rx_detected, rx_lock} = 4'b1100;
	end
	task automatic topo(input logic [3:0] n);
		topo_levels <= n;
		topo_update <= 1'b1;
		@(posedge clock);
		topo_update <= 1'b0;
		@(posedge clock);
	endtask
	task automatic keys(input logic [23:0] k);
		key_list_clear <= 1'b1;
		@(posedge clock);
		key_list_clear <= 1'b0;
		for (int i = 2; i >= 0; i--) begin
			key_byte <= k[i*8+:8];
			key_byte_valid <= 1'b1;
			@(posedge clock);
		end
		key_byte_valid <= 1'b0;
		key_list_done <= 1'b1;
		@(posedge clock);
		key_list_done <= 1'b0;
		key_byte <= ~key_byte;
		@(posedge clock);
	endtask
	task automatic activity;
		link_scl_in <= 1'b0;
		link_sda_in <= 1'b0;
		repeat (2) @(posedge clock);
		link_scl_in <= 1'b1;
		link_sda_in <= 1'b1;
		@(posedge clock);
	endtask
	task automatic link(input logic d, input logic l);
		rx_detected <= d;
		rx_lock <= l;
		@(posedge clock);
	endtask
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the protection register bank.
// Assumes: 40 ns clock, rst held 16 cycles, short timer parameters.
// Notes: Every task starts and ends just after a rising edge.
`timescale 1ns/1ns
module tb_top;
	logic clock, rst, reg_wr, reg_rd, frame_start, frame_inband_encrypt, authenticated;
	logic encryption_enable_control, pix_valid, line_end, topo_update, key_list_clear, key_byte_valid;
	logic key_list_done, link_scl_in, link_sda_in, bus_free, bus_fast_mode, encryption_enable_readback;
	logic frame_encrypt, integrity_check, integrity_sync_check, enhanced_check, csum_valid, auth_timer_tick;
	logic enhanced_signalling, repeater_mode, av_mute, rx_detected, rx_lock, irq;
	logic [3:0] topo_levels;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, key_byte, pix_red, pix_green, pix_blue;
	logic [7:0] csum_red, csum_green, csum_blue;
	int mismatches, checks_done, cyc, ni, ns, ne;
	time t;
	cpt_regs #(.BUS_TIMEOUT(25'd50), .AUTH_TICK(16'd64)) i_dut (.*);
	cpt_rx_model i_rx (.*);
	always #20 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 cmp(n, e, reg_rdata);
		@(posedge clock);
	endtask
	task automatic frame;
		frame_start <= 1'b1;
		@(posedge clock);
		frame_start <= 1'b0;
		#1 ni += int'(integrity_check);
		ns += int'(integrity_sync_check);
		ne += int'(enhanced_check);
		@(posedge clock);
	endtask
	task automatic run(input logic [7:0] d, input logic [7:0] c, input int n, input int ei, ei2, ee);
		wr(8'hC0, d);
		wr(8'hC2, c);
		ni = 0;
		ns = 0;
		ne = 0;
		repeat (n) frame();
		cmp("integrity", 8'(ei), 8'(ni));
		cmp("sync check", 8'(ei2), 8'(ns));
		cmp("enhanced", 8'(ee), 8'(ne));
	endtask
	task automatic irq_is(input logic e, input int n);
		repeat (n) @(posedge clock);
		#1 cmp("irq", 8'(e), 8'(irq));
		@(posedge clock);
	endtask
	task automatic gap(input int e);
		@(posedge auth_timer_tick);
		@(posedge auth_timer_tick);
		t = $time;
		@(posedge auth_timer_tick);
		cmp("tick gap", 8'(e), 8'(($time - t) / 40));
		@(posedge clock);
	endtask
	task automatic t_basic;
		rd(8'hC2, 8'hA8, "config");
		rd(8'h55, 8'h00, "unmapped");
		cmp("repeater", 8'h01, 8'(repeater_mode));
		wr(8'hC0, 8'hFF);
		#1 cmp("fast", 8'h01, 8'(bus_fast_mode));
		@(posedge clock);
		rd(8'hC0, 8'h5F, "debug");
		rd(8'hCA, 8'h01, "indirect");
		wr(8'hC0, 8'h02);
		gap(4);
		wr(8'hC0, 8'h00);
		gap(64);
		$display("t_basic done");
	endtask
	task automatic t_topo_keys;
		wr(8'hC9, 8'h02);
		i_rx.topo(4'h7);
		rd(8'hA2, 8'h07, "topology");
		cmp("irq", 8'h00, 8'(irq));
		i_rx.topo(4'h8);
		rd(8'hA2, 8'h08, "topology");
		cmp("irq", 8'h01, 8'(irq));
		wr(8'hC8, 8'h02);
		irq_is(1'b0, 0);
		wr(8'hC9, 8'h00);
		i_rx.keys(24'h3CA55A);
		rd(8'hCA, 8'h02, "indirect");
		reg_addr <= 8'hA3;
		reg_rd <= 1'b1;
		for (int i = 2; i >= 0; i--) begin
			@(posedge clock);
			if (i == 0) reg_rd <= 1'b0;
			#1 cmp("key byte", 8'(24'h3CA55A >> (i * 8)), reg_rdata);
		end
		@(posedge clock);
		rd(8'hA3, 8'h00, "key empty");
		$display("t_topo_keys done");
	endtask
	task automatic t_modes;
		authenticated <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			wr(8'hC2, 8'(m << 3));
			frame();
			cmp("encrypt", 8'(m % 2 == 0), 8'(frame_encrypt));
			cmp("readback", 8'(m == 2), 8'(encryption_enable_readback));
		end
		encryption_enable_control <= 1'b1;
		wr(8'hC2, 8'h08);
		frame();
		cmp("encrypt", 8'h01, 8'(frame_encrypt));
		cmp("readback", 8'h01, 8'(encryption_enable_readback));
		encryption_enable_control <= 1'b0;
		frame();
		cmp("encrypt", 8'h00, 8'(frame_encrypt));
		// Write then read with no gap between the strobes
		reg_addr <= 8'hC2;
		reg_wdata <= 8'h1C;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 cmp("config", 8'h1C, reg_rdata);
		@(posedge clock);
		wr(8'hC2, 8'h01);
		rd(8'hC2, 8'h00, "mute refused");
		wr(8'hC2, 8'h41);
		frame_inband_encrypt <= 1'b1;
		frame();
		cmp("mute", 8'h01, 8'(av_mute));
		cmp("muted encrypt", 8'h00, 8'(frame_encrypt));
		wr(8'hC2, 8'h40);
		frame();
		cmp("encrypt", 8'h01, 8'(frame_encrypt));
		cmp("eess", 8'h01, 8'(enhanced_signalling));
		run(8'h04, 8'h80, 16, 1, 1, 8);
		run(8'h14, 8'h00, 16, 1, 0, 0);
		run(8'h00, 8'h80, 128, 1, 1, 8);
		$display("t_modes done");
	endtask
	task automatic t_link;
		wr(8'hC0, 8'h08);
		pix_valid <= 1'b1;
		{pix_red, pix_green, pix_blue} <= 24'h0110FF;
		@(posedge clock);
		{pix_red, pix_green, pix_blue} <= 24'h022001;
		@(posedge clock);
		pix_valid <= 1'b0;
		line_end <= 1'b1;
		@(posedge clock);
		line_end <= 1'b0;
		#1 cmp("csum valid", 8'h01, 8'(csum_valid));
		cmp("csum", 8'hFC, csum_red);
		cmp("csum", 8'hCF, csum_green);
		cmp("csum", 8'hFE, csum_blue);
		@(posedge clock);
		i_rx.activity();
		repeat (40) @(posedge clock);
		#1 cmp("bus free", 8'h00, 8'(bus_free));
		repeat (30) @(posedge clock);
		#1 cmp("bus free", 8'h01, 8'(bus_free));
		@(posedge clock);
		wr(8'hC0, 8'h40);
		i_rx.activity();
		repeat (70) @(posedge clock);
		#1 cmp("bus free", 8'h00, 8'(bus_free));
		@(posedge clock);
		wr(8'hC2, 8'h02);
		wr(8'hC9, 8'h01);
		i_rx.link(1'b1, 1'b0);
		irq_is(1'b0, 4);
		i_rx.link(1'b1, 1'b1);
		irq_is(1'b1, 4);
		wr(8'hC8, 8'h01);
		irq_is(1'b0, 0);
		i_rx.link(1'b0, 1'b0);
		wr(8'hC9, 8'h00);
		wr(8'hC2, 8'h00);
		i_rx.link(1'b1, 1'b0);
		irq_is(1'b0, 4);
		wr(8'hC9, 8'h01);
		irq_is(1'b1, 0);
		$display("t_link done");
	endtask
	initial begin
		clock = 1'b0;
		rst = 1'b1;
		{reg_wr, reg_rd, frame_start, frame_inband_encrypt, authenticated, encryption_enable_control} = '0;
		{pix_valid, line_end, reg_addr, reg_wdata, pix_red, pix_green, pix_blue} = '0;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_basic();
		t_topo_keys();
		t_modes();
		t_link();
		final_report();
	end
endmodule
